// ==== src/pldc_cell.sv ====
`default_nettype none
// Summary of operation
// - each product-term array takes twelve routing inputs into eight product terms
// - a term ANDs one to twelve inputs, each true or inverted
// - each array output ORs a chosen set of the eight terms
// - all outputs share the same eight terms, same OR width
// - the cell holds two product-term arrays and one datapath
// - each array output is combinational or registered, by select
// - datapath does 8-bit alu work in one clock cycle
// - two accumulators, two data registers, two queues, bus readable and writable
// - accumulators feed alu, load from alu, feed compares
// - data registers feed alu and compares, never written by alu
// - each queue head can load either data register or accumulator
// - each queue can capture an accumulator or the alu result
// - each queue holds four bytes in first-in first-out order
// - queues are the main exchange between bus masters and datapath
// - two compares, two zero, two all-ones and overflow conditions out
// - operation picked each cycle from eight 16-bit configuration words
module pldc_cell
	import pldc_pkg::*;
(
	input  wire logic                    mclk,         // clock
	input  wire logic                    reset,        // sync reset
	input  wire logic                    ce,           // clock enable
	input  wire logic [1:0][11:0]        pld_in,       // array inputs
	input  wire logic [1:0][7:0][11:0]   pld_and_true, // true-polarity picks
	input  wire logic [1:0][7:0][11:0]   pld_and_comp, // inverted picks
	input  wire logic [1:0][3:0][7:0]    pld_or_sel,   // term picks per output
	input  wire logic [1:0][3:0]         pld_reg_sel,  // registered output select
	output logic      [1:0][3:0]         pld_out,      // array outputs
	input  wire logic                    cfg_we,       // config store write
	input  wire logic [2:0]              cfg_waddr,    // config write index
	input  wire logic [15:0]             cfg_wdata,    // config write word
	input  wire logic [2:0]              cfg_addr,     // per-cycle config select
	input  wire logic [1:0]              q_dir,        // 1: queue is output buffer
	input  wire logic [1:0][1:0]         q_cap_src,    // capture source per queue
	input  wire logic                    bus_wr,       // bus write strobe
	input  wire logic                    bus_rd,       // bus read strobe
	input  wire logic [2:0]              bus_addr,     // register index
	input  wire logic [7:0]              bus_wdata,    // write data
	output logic      [7:0]              bus_rdata,    // read data
	output logic                         bus_rvalid,   // read data valid
	output logic                         cond_cmp0,    // accumulator 0 equals data 0
	output logic                         cond_cmp1,    // accumulator 1 equals data 1
	output logic                         cond_zero0,   // accumulator 0 zero
	output logic                         cond_zero1,   // accumulator 1 zero
	output logic                         cond_ones0,   // accumulator 0 all ones
	output logic                         cond_ones1,   // accumulator 1 all ones
	output logic                         cond_ovf,     // last operation overflowed
	output logic                         dp_stall,     // datapath held this cycle
	output logic                         stream_valid, // result stream entry
	input  wire logic                    stream_ready, // result stream taken
	output logic      [7:0]              stream_data   // result stream byte
);
	logic [15:0]      cfg_store [PLDC_CFG_N];
	logic [15:0]      cfg_word;
	logic [7:0]       acc0, acc1, dat0, dat1, opa, opb, alu_res;
	logic [8:0]       alu_full;
	logic [2:0]       op;
	logic [1:0]       a0_sel, a1_sel, d0_sel, d1_sel;
	logic             cap, push, stall_q, go, s_in_ready;
	logic             wr_a0, wr_a1, wr_d0, wr_d1;
	logic [1:0]       use_q, q_in_valid, q_in_ready, q_out_valid, q_out_ready;
	logic [1:0][7:0]  q_in_data, q_head, cap_data, pt;
	logic [1:0][3:0]  pld_sum, pld_ff;

	function automatic logic [8:0] pldc_alu(input logic [2:0] f, input logic [7:0] a,
			input logic [7:0] b);
		logic [8:0] r;
		r = '0;
		case (f)
			PLDC_OP_INC:  r = {1'b0, a} + {1'b0, PLDC_ONE};
			PLDC_OP_DEC:  r = {1'b0, a} - {1'b0, PLDC_ONE};
			PLDC_OP_ADD:  r = {1'b0, a} + {1'b0, b};
			PLDC_OP_SUB:  r = {1'b0, a} - {1'b0, b};
			PLDC_OP_AND:  r = {1'b0, a & b};
			PLDC_OP_OR:   r = {1'b0, a | b};
			PLDC_OP_XOR:  r = {1'b0, a ^ b};
			default:      r = {1'b0, a};
		endcase
		return r;
	endfunction

	function automatic logic pldc_ovf(input logic [2:0] f, input logic [7:0] a,
			input logic [7:0] b, input logic [7:0] r);
		logic v;
		v = 1'b0;
		case (f)
			PLDC_OP_INC: v = (a == PLDC_MAXP);
			PLDC_OP_DEC: v = (a == PLDC_MINN);
			PLDC_OP_ADD: v = (a[7] == b[7]) && (r[7] != a[7]);
			PLDC_OP_SUB: v = (a[7] != b[7]) && (r[7] != a[7]);
			default:     v = 1'b0;
		endcase
		return v;
	endfunction

	// load mux shared by all four working registers
	function automatic logic [7:0] pldc_load(input logic [1:0] s, input logic [7:0] cur,
			input logic [7:0] alu, input logic [7:0] h0, input logic [7:0] h1);
		logic [7:0] v;
		v = cur;
		case (s)
			PLDC_LD_ALU: v = alu;
			PLDC_LD_Q0:  v = h0;
			PLDC_LD_Q1:  v = h1;
			default:     v = cur;
		endcase
		return v;
	endfunction

	function automatic logic [1:0] pldc_uses(input logic [1:0] s);
		return {s == PLDC_LD_Q1, s == PLDC_LD_Q0};
	endfunction

	for (genvar g = 0; g < PLDC_PLD_N; g++) begin : g_pld
		for (genvar t = 0; t < PLDC_PLD_PT; t++) begin : g_term
			assign pt[g][t] = ((pld_and_true[g][t] | pld_and_comp[g][t]) != '0) &&
				(&((~pld_and_true[g][t] | pld_in[g]) & (~pld_and_comp[g][t] | ~pld_in[g])));
		end
		for (genvar o = 0; o < PLDC_PLD_OUT; o++) begin : g_out
			assign pld_sum[g][o] = |(pt[g] & pld_or_sel[g][o]);
			assign pld_out[g][o] = pld_reg_sel[g][o] ? pld_ff[g][o] : pld_sum[g][o];
		end
		always_ff @(posedge mclk) begin
			if (reset) begin
				pld_ff[g] <= '0;
			end else if (ce) begin
				pld_ff[g] <= pld_sum[g];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (ce && cfg_we) begin
			cfg_store[cfg_waddr] <= cfg_wdata;
		end
	end
	assign cfg_word = cfg_store[cfg_addr];

	assign op     = cfg_word[PLDC_CF_OP_HI:PLDC_CF_OP_LO];
	assign a0_sel = cfg_word[PLDC_CF_A0_HI:PLDC_CF_A0_LO];
	assign a1_sel = cfg_word[PLDC_CF_A1_HI:PLDC_CF_A1_LO];
	assign d0_sel = (cfg_word[PLDC_CF_D0_HI:PLDC_CF_D0_LO] == PLDC_LD_ALU) ? PLDC_LD_HOLD :
		cfg_word[PLDC_CF_D0_HI:PLDC_CF_D0_LO];
	assign d1_sel = (cfg_word[PLDC_CF_D1_HI:PLDC_CF_D1_LO] == PLDC_LD_ALU) ? PLDC_LD_HOLD :
		cfg_word[PLDC_CF_D1_HI:PLDC_CF_D1_LO];
	assign cap    = cfg_word[PLDC_CF_CAP];
	assign push   = cfg_word[PLDC_CF_PUSH];

	assign opa = cfg_word[PLDC_CF_SRCA] ? acc1 : acc0;
	always_comb begin
		case (cfg_word[PLDC_CF_SRCB_HI:PLDC_CF_SRCB_LO])
			PLDC_B_DAT0: opb = dat0;
			PLDC_B_DAT1: opb = dat1;
			PLDC_B_ACC0: opb = acc0;
			default:     opb = acc1;
		endcase
	end
	assign alu_full = pldc_alu(op, opa, opb);
	assign alu_res  = alu_full[7:0];

	// only input-buffer queues are popped by loads; missing head or full sink holds datapath
	assign use_q   = (pldc_uses(a0_sel) | pldc_uses(a1_sel) | pldc_uses(d0_sel) |
		pldc_uses(d1_sel)) & ~q_dir;
	assign stall_q = (|(use_q & ~q_out_valid)) | (cap & (|(q_dir & ~q_in_ready)));
	assign go      = ce & ~stall_q & ~(push & ~s_in_ready);
	assign dp_stall = ce & ~go;

	assign wr_a0 = bus_wr && (bus_addr == PLDC_ADDR_ACC0);
	assign wr_a1 = bus_wr && (bus_addr == PLDC_ADDR_ACC1);
	assign wr_d0 = bus_wr && (bus_addr == PLDC_ADDR_DAT0);
	assign wr_d1 = bus_wr && (bus_addr == PLDC_ADDR_DAT1);

	always_ff @(posedge mclk) begin
		if (reset) begin
			acc0 <= '0;
		end else if (ce && wr_a0) begin
			acc0 <= bus_wdata;
		end else if (go) begin
			acc0 <= pldc_load(a0_sel, acc0, alu_res, q_head[0], q_head[1]);
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			acc1 <= '0;
		end else if (ce && wr_a1) begin
			acc1 <= bus_wdata;
		end else if (go) begin
			acc1 <= pldc_load(a1_sel, acc1, alu_res, q_head[0], q_head[1]);
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			dat0 <= '0;
			dat1 <= '0;
		end else if (ce) begin
			if (wr_d0) begin
				dat0 <= bus_wdata;
			end else if (go) begin
				dat0 <= pldc_load(d0_sel, dat0, alu_res, q_head[0], q_head[1]);
			end
			if (wr_d1) begin
				dat1 <= bus_wdata;
			end else if (go) begin
				dat1 <= pldc_load(d1_sel, dat1, alu_res, q_head[0], q_head[1]);
			end
		end
	end

	for (genvar q = 0; q < PLDC_Q_N; q++) begin : g_q
		assign cap_data[q] = (q_cap_src[q] == PLDC_CAP_ACC0) ? acc0 :
			(q_cap_src[q] == PLDC_CAP_ACC1) ? acc1 : alu_res;
		assign q_in_valid[q] = q_dir[q] ? (go & cap) :
			(bus_wr && (bus_addr == (PLDC_ADDR_Q0 + 3'(q))));
		assign q_in_data[q] = q_dir[q] ? cap_data[q] : bus_wdata;
		assign q_out_ready[q] = q_dir[q] ? (bus_rd && (bus_addr == (PLDC_ADDR_Q0 + 3'(q)))) :
			(go & use_q[q]);
		pldc_fifo #(.WIDTH(PLDC_DW), .DEPTH(PLDC_Q_DEPTH)) u_queue (
			.mclk      (mclk),
			.reset     (reset),
			.ce        (ce),
			.in_valid  (q_in_valid[q]),
			.in_ready  (q_in_ready[q]),
			.in_data   (q_in_data[q]),
			.out_valid (q_out_valid[q]),
			.out_ready (q_out_ready[q]),
			.out_data  (q_head[q])
		);
	end

	// result stream toward routing, back-pressure stalls datapath
	pldc_fifo #(.WIDTH(PLDC_DW), .DEPTH(PLDC_S_DEPTH)) u_stream (
		.mclk      (mclk),
		.reset     (reset),
		.ce        (ce),
		.in_valid  (go & push),
		.in_ready  (s_in_ready),
		.in_data   (alu_res),
		.out_valid (stream_valid),
		.out_ready (stream_ready),
		.out_data  (stream_data)
	);

	always_ff @(posedge mclk) begin
		if (reset) begin
			bus_rdata  <= '0;
			bus_rvalid <= 1'b0;
		end else if (ce) begin
			bus_rvalid <= bus_rd;
			if (bus_rd) begin
				if (bus_addr == PLDC_ADDR_ACC0) begin
					bus_rdata <= acc0;
				end else if (bus_addr == PLDC_ADDR_ACC1) begin
					bus_rdata <= acc1;
				end else if (bus_addr == PLDC_ADDR_DAT0) begin
					bus_rdata <= dat0;
				end else if (bus_addr == PLDC_ADDR_DAT1) begin
					bus_rdata <= dat1;
				end else if (bus_addr == PLDC_ADDR_Q0) begin
					bus_rdata <= q_out_valid[0] ? q_head[0] : PLDC_ZERO;
				end else if (bus_addr == PLDC_ADDR_Q1) begin
					bus_rdata <= q_out_valid[1] ? q_head[1] : PLDC_ZERO;
				end else begin
					bus_rdata <= PLDC_ZERO;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			{cond_cmp0, cond_cmp1, cond_zero0, cond_zero1} <= '0;
			{cond_ones0, cond_ones1, cond_ovf} <= '0;
		end else if (ce) begin
			cond_cmp0  <= (acc0 == dat0);
			cond_cmp1  <= (acc1 == dat1);
			cond_zero0 <= (acc0 == PLDC_ZERO);
			cond_zero1 <= (acc1 == PLDC_ZERO);
			cond_ones0 <= (acc0 == PLDC_ONES);
			cond_ones1 <= (acc1 == PLDC_ONES);
			if (go) begin
				cond_ovf <= pldc_ovf(op, opa, opb, alu_res);
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_alu_load;
		go && !reset && a0_sel == PLDC_LD_ALU && !wr_a0;
	endsequence
	sequence s_cfg_write;
		ce && cfg_we ##1 !cfg_we && cfg_addr == $past(cfg_waddr);
	endsequence
	a_alu_single_cycle: assert property (s_alu_load |=> acc0 == $past(alu_res))
		else $error("accumulator 0 missed alu result");
	a_acc1_queue_load: assert property (go && a1_sel == PLDC_LD_Q0
		&& !wr_a1 && !q_dir[0] |=> acc1 == $past(q_head[0]))
		else $error("accumulator 1 missed queue head");
	a_data_hold: assert property (go && !reset && d0_sel == PLDC_LD_HOLD
		&& !wr_d0 |=> $stable(dat0))
		else $error("data register 0 changed without load");
	a_missing_head: assert property (ce && use_q[0] && !q_out_valid[0] && !wr_a0
		|=> acc0 == $past(acc0))
		else $error("datapath ran on empty queue");
	a_capture_push: assert property (go && cap && q_dir[1] && q_cap_src[1][1]
		|-> q_in_valid[1] && q_in_data[1] == alu_res)
		else $error("queue 1 capture lost");
	a_cond_zero: assert property (ce && !reset && acc0 == PLDC_ZERO ##1 ce |-> cond_zero0)
		else $error("zero detect missed");
	a_pld_registered: assert property (ce && !reset && pld_reg_sel[0][0]
		##1 pld_reg_sel[0][0] |-> pld_out[0][0] == $past(pld_sum[0][0]))
		else $error("registered array output wrong");
	a_cfg_select: assert property (s_cfg_write |-> cfg_word == $past(cfg_wdata))
		else $error("config word not selected");
	a_stream_stall: assert property (ce && push && !s_in_ready && !wr_a0
		|=> acc0 == $past(acc0))
		else $error("datapath ran into full stream");
	a_bus_read: assert property (ce && bus_rd && bus_addr == PLDC_ADDR_ACC0
		|=> bus_rvalid && bus_rdata == $past(acc0))
		else $error("bus read of accumulator 0 wrong");
endmodule
`default_nettype wire

// ==== src/pldc_pkg.sv ====
`default_nettype none
package pldc_pkg;
	localparam int PLDC_DW        = 8;
	localparam int PLDC_CFG_W     = 16;
	localparam int PLDC_CFG_N     = 8;
	localparam int PLDC_CFG_AW    = 3;
	localparam int PLDC_PLD_N     = 2;
	localparam int PLDC_PLD_IN    = 12;
	localparam int PLDC_PLD_PT    = 8;
	localparam int PLDC_PLD_OUT   = 4;
	localparam int PLDC_Q_N       = 2;
	localparam int PLDC_Q_DEPTH   = 4;
	localparam int PLDC_S_DEPTH   = 8;
	localparam int PLDC_AW        = 3;

	// register indices on the system bus port
	localparam logic [2:0] PLDC_ADDR_ACC0 = 3'h0;
	localparam logic [2:0] PLDC_ADDR_ACC1 = 3'h1;
	localparam logic [2:0] PLDC_ADDR_DAT0 = 3'h2;
	localparam logic [2:0] PLDC_ADDR_DAT1 = 3'h3;
	localparam logic [2:0] PLDC_ADDR_Q0   = 3'h4;
	localparam logic [2:0] PLDC_ADDR_Q1   = 3'h5;

	// configuration word fields
	localparam int PLDC_CF_OP_LO   = 0;
	localparam int PLDC_CF_OP_HI   = 2;
	localparam int PLDC_CF_SRCA    = 3;
	localparam int PLDC_CF_SRCB_LO = 4;
	localparam int PLDC_CF_SRCB_HI = 5;
	localparam int PLDC_CF_A0_LO   = 6;
	localparam int PLDC_CF_A0_HI   = 7;
	localparam int PLDC_CF_A1_LO   = 8;
	localparam int PLDC_CF_A1_HI   = 9;
	localparam int PLDC_CF_D0_LO   = 10;
	localparam int PLDC_CF_D0_HI   = 11;
	localparam int PLDC_CF_D1_LO   = 12;
	localparam int PLDC_CF_D1_HI   = 13;
	localparam int PLDC_CF_CAP     = 14;
	localparam int PLDC_CF_PUSH    = 15;

	// alu operations
	localparam logic [2:0] PLDC_OP_INC  = 3'h0;
	localparam logic [2:0] PLDC_OP_DEC  = 3'h1;
	localparam logic [2:0] PLDC_OP_ADD  = 3'h2;
	localparam logic [2:0] PLDC_OP_SUB  = 3'h3;
	localparam logic [2:0] PLDC_OP_AND  = 3'h4;
	localparam logic [2:0] PLDC_OP_OR   = 3'h5;
	localparam logic [2:0] PLDC_OP_XOR  = 3'h6;
	localparam logic [2:0] PLDC_OP_PASS = 3'h7;

	// load selects: hold, alu result, queue 0 head, queue 1 head
	localparam logic [1:0] PLDC_LD_HOLD = 2'h0;
	localparam logic [1:0] PLDC_LD_ALU  = 2'h1;
	localparam logic [1:0] PLDC_LD_Q0   = 2'h2;
	localparam logic [1:0] PLDC_LD_Q1   = 2'h3;

	// operand b selects and queue capture sources
	localparam logic [1:0] PLDC_B_DAT0  = 2'h0;
	localparam logic [1:0] PLDC_B_DAT1  = 2'h1;
	localparam logic [1:0] PLDC_B_ACC0  = 2'h2;
	localparam logic [1:0] PLDC_CAP_ACC0 = 2'h0;
	localparam logic [1:0] PLDC_CAP_ACC1 = 2'h1;

	localparam logic [7:0] PLDC_ZERO  = 8'h00;
	localparam logic [7:0] PLDC_ONES  = 8'hff;
	localparam logic [7:0] PLDC_MAXP  = 8'h7f;
	localparam logic [7:0] PLDC_MINN  = 8'h80;
	localparam logic [7:0] PLDC_ONE   = 8'h01;
endpackage
`default_nettype wire

// ==== src/pldc_fifo.sv ====
`default_nettype none
module pldc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,      // clock
	input  wire logic             reset,     // sync reset
	input  wire logic             ce,        // clock enable
	input  wire logic             in_valid,  // push request
	output logic                  in_ready,  // room available
	input  wire logic [WIDTH-1:0] in_data,   // push data
	output logic                  out_valid, // entry available
	input  wire logic             out_ready, // pop request
	output logic      [WIDTH-1:0] out_data   // head entry
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             do_push;
	logic             do_pop;

	assign in_ready  = (count != CNT_FULL);
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	// full push and empty pop leave storage untouched
	assign do_push   = ce & in_valid & in_ready;
	assign do_pop    = ce & out_ready & out_valid;

	always_ff @(posedge mclk) begin
		if (do_push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			count <= '0;
		end else if (do_push & ~do_pop) begin
			count <= count + 1'b1;
		end else if (do_pop & ~do_push) begin
			count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== tb/pldc_sink.sv ====
`default_nettype none
module pldc_sink (
	input  wire logic       mclk,         // clock
	input  wire logic       reset,        // sync reset
	input  wire logic       hold,         // refuse every entry
	input  wire logic       stream_valid, // entry offered
	input  wire logic [7:0] stream_data,  // offered byte
	output logic            stream_ready  // entry taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt;
	logic [7:0] got[$];
	// slow taker, idle one cycle in four
	assign stream_ready = !hold && cnt != 2'h0;
	always_ff @(posedge mclk) begin
		cnt <= reset ? 2'h0 : cnt + 2'h1;
		if (!reset && stream_valid && stream_ready)
			got.push_back(stream_data);
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top
	import pldc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic                  mclk = 1'b0, reset = 1'b1, ce = 1'b1, hold = 1'b1;
	logic                  cfg_we = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
	logic [2:0]            cfg_waddr = 3'h0, cfg_addr = 3'h0, bus_addr = 3'h0;
	logic [15:0]           cfg_wdata = 16'h0000;
	logic [1:0]            q_dir = 2'h2;
	logic [1:0][1:0]       q_cap_src = 4'h8;
	logic [7:0]            bus_wdata = 8'h00, bus_rdata, stream_data;
	logic [1:0][11:0]      pld_in = '0;
	logic [1:0][7:0][11:0] pld_and_true = '0, pld_and_comp = '0;
	logic [1:0][3:0][7:0]  pld_or_sel = '0;
	logic [1:0][3:0]       pld_reg_sel = '0, pld_out;
	logic                  bus_rvalid, stream_valid, stream_ready, dp_stall, cond_ovf;
	logic                  cond_cmp0, cond_cmp1, cond_zero0, cond_zero1, cond_ones0, cond_ones1;
	logic [31:0]           seed = 32'hf5b0;
	int                    n_fail = 0, checks = 0, cyc = 0;

	pldc_cell uut (.mclk(mclk), .reset(reset), .ce(ce), .pld_in(pld_in),
		.pld_and_true(pld_and_true), .pld_and_comp(pld_and_comp), .pld_or_sel(pld_or_sel),
		.pld_reg_sel(pld_reg_sel), .pld_out(pld_out), .cfg_we(cfg_we), .cfg_waddr(cfg_waddr),
		.cfg_wdata(cfg_wdata), .cfg_addr(cfg_addr), .q_dir(q_dir), .q_cap_src(q_cap_src),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .cond_cmp0(cond_cmp0),
		.cond_cmp1(cond_cmp1), .cond_zero0(cond_zero0), .cond_zero1(cond_zero1),
		.cond_ones0(cond_ones0), .cond_ones1(cond_ones1), .cond_ovf(cond_ovf),
		.dp_stall(dp_stall), .stream_valid(stream_valid), .stream_ready(stream_ready),
		.stream_data(stream_data));
	pldc_sink p (.mclk(mclk), .reset(reset), .hold(hold), .stream_valid(stream_valid),
		.stream_data(stream_data), .stream_ready(stream_ready));

	initial begin
		forever #4 mclk = ~mclk;
	end

	function automatic logic [7:0] xs8();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// {overflow, result}; overflow is signed, arithmetic ops only
	function automatic logic [8:0] alu(input logic [2:0] op, input logic [7:0] a,
			input logic [7:0] b);
		logic [7:0] r;
		logic [7:0] c;
		c = op < 3'h2 ? PLDC_ONE : b;
		case (op)
			PLDC_OP_INC, PLDC_OP_ADD: r = a + c;
			PLDC_OP_DEC, PLDC_OP_SUB: r = a - c;
			PLDC_OP_AND: r = a & b;
			PLDC_OP_OR: r = a | b;
			PLDC_OP_XOR: r = a ^ b;
			default: r = a;
		endcase
		return {op < 3'h4 && (a[7] ^ c[7]) == op[0] && r[7] != a[7], r};
	endfunction

	function automatic logic [3:0] pld(input int k);
		logic [7:0] t;
		logic [3:0] o;
		for (int i = 0; i < 8; i++)
			t[i] = |(pld_and_true[k][i] | pld_and_comp[k][i]) && &((~pld_and_true[k][i]
				| pld_in[k]) & (~pld_and_comp[k][i] | ~pld_in[k]));
		for (int j = 0; j < 4; j++)
			o[j] = |(t & pld_or_sel[k][j]);
		return o;
	endfunction

	task automatic print_verdict();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge mclk);
		bus_wr <= 1'b0;
	endtask

	task automatic rc(input logic [2:0] a, input logic [7:0] exp);
		@(posedge mclk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge mclk);
		bus_rd <= 1'b0;
		#1;
		chk({7'h0, bus_rvalid}, 8'h01);
		chk(bus_rdata, exp);
	endtask

	task automatic cfg(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk);
		cfg_we <= 1'b1;
		cfg_waddr <= a;
		cfg_wdata <= d;
		@(posedge mclk);
		cfg_we <= 1'b0;
	endtask

	// one datapath step from word w, stall sampled before the executing edge
	task automatic run(input logic [2:0] w, input logic st);
		@(posedge mclk);
		cfg_addr <= w;
		#1;
		chk({7'h0, dp_stall}, {7'h0, st});
		@(posedge mclk);
		cfg_addr <= 3'h0;
		#1;
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			print_verdict();
		end
	end

	initial begin
		logic [7:0] a, b, d;
		logic [8:0] e;
		logic [7:0] q[5];
		logic [1:0][3:0] pv, cv;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		// idle word, then queue load, capture, stream push, acc1 add
		cfg(3'h0, 16'h0007);
		cfg(3'h2, 16'h0287);
		cfg(3'h3, 16'h4040);
		cfg(3'h4, 16'h8040);
		cfg(3'h5, 16'h051a);
		// second reset clears what ran before the store was filled
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		#1;
		chk({cond_cmp0, cond_cmp1, cond_zero0, cond_zero1, cond_ones0, cond_ones1, cond_ovf,
			stream_valid}, 8'h00);
		for (int i = 0; i < 8; i++)
			rc(3'(i), 8'h00);
		$display("reset test done");
		for (int op = 0; op < 8; op++) begin
			a = xs8();
			b = xs8();
			if (op < 2)
				a = op ? PLDC_MINN : PLDC_MAXP;
			e = alu(3'(op), a, b);
			wr(PLDC_ADDR_ACC0, a);
			wr(PLDC_ADDR_DAT0, b);
			cfg(3'h1, 16'h0040 | 16'(op));
			run(3'h1, 1'b0);
			chk({7'h0, cond_ovf}, {7'h0, e[8]});
			rc(PLDC_ADDR_ACC0, e[7:0]);
			chk({5'h0, cond_zero0, cond_ones0, cond_cmp0},
				{5'h0, e[7:0] == PLDC_ZERO, e[7:0] == PLDC_ONES, e[7:0] == b});
		end
		a = xs8();
		b = xs8();
		d = xs8();
		wr(PLDC_ADDR_ACC1, a);
		wr(PLDC_ADDR_DAT1, b);
		wr(PLDC_ADDR_DAT0, d);
		run(3'h5, 1'b0);
		rc(PLDC_ADDR_ACC1, a + b);
		rc(PLDC_ADDR_DAT0, d);
		chk({5'h0, cond_zero1, cond_ones1, cond_cmp1},
			{5'h0, a + b == PLDC_ZERO, a + b == PLDC_ONES, a + b == b});
		$display("alu test done");
		for (int i = 0; i < 5; i++) begin
			q[i] = xs8();
			wr(PLDC_ADDR_Q0, q[i]);
		end
		rc(PLDC_ADDR_Q0, q[0]);
		for (int i = 0; i < 5; i++) begin
			run(3'h2, i == 4);
			rc(PLDC_ADDR_ACC0, q[i < 4 ? i : 3]);
		end
		rc(PLDC_ADDR_ACC1, q[3]);
		a = xs8();
		wr(PLDC_ADDR_ACC0, a);
		for (int i = 0; i < 5; i++)
			run(3'h3, i == 4);
		rc(PLDC_ADDR_ACC0, a + 8'h04);
		for (int i = 1; i < 5; i++)
			rc(PLDC_ADDR_Q1, a + 8'(i));
		wr(PLDC_ADDR_Q1, 8'hee);
		rc(PLDC_ADDR_Q1, 8'h00);
		$display("queue test done");
		a = xs8();
		wr(PLDC_ADDR_ACC0, a);
		for (int i = 0; i < 9; i++)
			run(3'h4, i == 8);
		@(posedge mclk);
		hold <= 1'b0;
		for (int i = 0; i < 60 && p.got.size() < 8; i++)
			@(posedge mclk);
		chk(8'(p.got.size()), 8'h08);
		for (int i = 0; i < 8; i++)
			chk(p.got[i], a + 8'(i) + 8'h01);
		$display("stream test done");
		@(posedge mclk);
		ce <= 1'b0;
		wr(PLDC_ADDR_ACC0, ~a);
		run(3'h4, 1'b0);
		@(posedge mclk);
		ce <= 1'b1;
		rc(PLDC_ADDR_ACC0, a + 8'h08);
		$display("freeze test done");
		for (int n = 0; n < 24; n++) begin
			@(posedge mclk);
			for (int k = 0; k < 2; k++) begin
				pld_in[k] <= 12'({xs8(), xs8()});
				for (int i = 0; i < 8; i++) begin
					pld_and_true[k][i] <= 12'(xs8() & xs8() & xs8());
					pld_and_comp[k][i] <= 12'({xs8() & xs8() & xs8(), 4'h0});
				end
				pld_or_sel[k] <= {xs8(), xs8(), xs8(), xs8()};
				pld_reg_sel[k] <= 4'(xs8());
			end
			@(posedge mclk);
			pv = {pld(1), pld(0)};
			pld_in <= {12'({xs8(), xs8()}), 12'({xs8(), xs8()})};
			#1;
			cv = {pld(1), pld(0)};
			chk(pld_out, (pv & pld_reg_sel) | (cv & ~pld_reg_sel));
		end
		$display("array test done");
		print_verdict();
	end
endmodule
`default_nettype wire
